/* rtl/tpg_defs.svh */
// constants for the test pattern frame timing core
// ****************************************************************
// Overview of operation
// - line length is 16 bits; emit exactly that many bytes
// - line length resets to 1920 bytes (640 pixels)
// - 16-bit bar width applies to all but last bar
// - last bar fills the remaining line bytes
// - 16-bit active line count, resets to 480
// - 16-bit total line count includes vertical blanking
// - 16-bit line period in link rate units
// - resets: bar 0x00F0, total 0x020D, period 0x0C67
// - bar count setting: 1, 2, 4 or 8 bars
// - blank lines between frame start and first data
// ****************************************************************
`ifndef TPG_DEFS_SVH
`define TPG_DEFS_SVH

// register offsets
`define TPG_OFS_FIRST          8'h04
`define TPG_OFS_LAST           8'h0D
`define TPG_NUM_REGS           10
`define TPG_IDX_LEN_HI         0
`define TPG_IDX_LEN_LO         1
`define TPG_IDX_BAR_HI         2
`define TPG_IDX_BAR_LO         3
`define TPG_IDX_ACT_HI         4
`define TPG_IDX_ACT_LO         5
`define TPG_IDX_TOT_HI         6
`define TPG_IDX_TOT_LO         7
`define TPG_IDX_PD_HI          8
`define TPG_IDX_PD_LO          9

// reset values
`define TPG_RST_LEN_HI         8'h07
`define TPG_RST_LEN_LO         8'h80
`define TPG_RST_BAR_HI         8'h00
`define TPG_RST_BAR_LO         8'hF0
`define TPG_RST_ACT_HI         8'h01
`define TPG_RST_ACT_LO         8'hE0
`define TPG_RST_TOT_HI         8'h02
`define TPG_RST_TOT_LO         8'h0D
`define TPG_RST_PD_HI          8'h0C
`define TPG_RST_PD_LO          8'h67

// timing: clk cycles per line period unit (40 / link rate)
`define TPG_UNIT_CLKS          16'h0001

`endif

/* rtl/tpg_pkg.sv */
// types for the test pattern frame timing core
package tpg_pkg;

	// kind of beat sent on the packet path
	typedef enum logic [1:0]
	{
		TPG_BEAT_FS,
		TPG_BEAT_DATA,
		TPG_BEAT_FE
	} tpg_kind_t;

	// one beat toward the packet transmit path
	typedef struct packed
	{
		tpg_kind_t   kind;       // frame start, data, frame end
		logic        line_first; // first byte of active line
		logic        line_last;  // last byte of active line
		logic [2:0]  bar;        // color bar index of the byte
		logic [15:0] line;       // active line number
	} tpg_beat_t;

	// generator states
	typedef enum logic [2:0]
	{
		TPG_ST_FS,
		TPG_ST_LINE,
		TPG_ST_DATA,
		TPG_ST_WAIT,
		TPG_ST_FE
	} tpg_state_t;

endpackage

/* rtl/tpg_frame_timing.sv */
// frame, line and color bar timing for the test pattern generator
`timescale 1ns/1ps
`include "tpg_defs.svh"

module tpg_frame_timing
	import tpg_pkg::*;
(
	// clock and reset
	input  wire logic      clk,
	input  wire logic      resetn,
	// indirect register access port
	input  wire logic [7:0] reg_addr,
	input  wire logic      reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic      reg_rd,
	output logic     [7:0] reg_rdata,
	// pattern setup outside the timing registers
	input  wire logic [1:0] color_bar_count,
	input  wire logic [7:0] top_blank_lines,
	// packet path
	output logic           out_valid,
	input  wire logic      out_ready,
	output tpg_beat_t      out_beat,
	// status
	output logic [15:0]    line_index
);

	// ****************************************************************
	// register file
	// ****************************************************************
	localparam logic [7:0] RST_VAL [`TPG_NUM_REGS] = '{
		`TPG_RST_LEN_HI, `TPG_RST_LEN_LO, `TPG_RST_BAR_HI, `TPG_RST_BAR_LO,
		`TPG_RST_ACT_HI, `TPG_RST_ACT_LO, `TPG_RST_TOT_HI, `TPG_RST_TOT_LO,
		`TPG_RST_PD_HI,  `TPG_RST_PD_LO};

	logic [7:0] regs_q [`TPG_NUM_REGS]; // byte registers
	logic       hit;                     // address in the map
	logic [3:0] idx;                     // register index

	assign hit = (reg_addr >= `TPG_OFS_FIRST) && (reg_addr <= `TPG_OFS_LAST);
	assign idx = 4'(reg_addr - `TPG_OFS_FIRST);

	// one byte register per entry, reset to its default
	genvar g;
	generate
		for (g = 0; g < `TPG_NUM_REGS; g++)
		begin : g_reg
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					regs_q[g] <= RST_VAL[g];
				else if (reg_wr && hit && idx == 4'(g))
					regs_q[g] <= reg_wdata;
			end
		end
	endgenerate

	// registered read data, zero outside the map
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= hit ? regs_q[idx] : 8'h00;
	end

	// ****************************************************************
	// frame shadow values
	// ****************************************************************
	tpg_state_t  st_q;        // generator state
	logic [15:0] len_q;       // active line bytes
	logic [15:0] bar_w_q;     // bar width bytes
	logic [15:0] act_q;       // active lines per frame
	logic [15:0] tot_q;       // total lines per frame
	logic [15:0] pd_q;        // line period count
	logic [3:0]  nbars_q;     // bars per line
	logic [7:0]  vbp_q;       // top blank lines
	logic        push;        // beat accepted by buffer
	logic        buf_ready;   // buffer can take a beat

	// capture all values at once as each frame starts
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			len_q   <= {`TPG_RST_LEN_HI, `TPG_RST_LEN_LO};
			bar_w_q <= {`TPG_RST_BAR_HI, `TPG_RST_BAR_LO};
			act_q   <= {`TPG_RST_ACT_HI, `TPG_RST_ACT_LO};
			tot_q   <= {`TPG_RST_TOT_HI, `TPG_RST_TOT_LO};
			pd_q    <= {`TPG_RST_PD_HI, `TPG_RST_PD_LO};
			nbars_q <= 4'h8;
			vbp_q   <= 8'h00;
		end
		else if (st_q == TPG_ST_FS && push)
		begin
			len_q   <= {regs_q[`TPG_IDX_LEN_HI], regs_q[`TPG_IDX_LEN_LO]};
			bar_w_q <= {regs_q[`TPG_IDX_BAR_HI], regs_q[`TPG_IDX_BAR_LO]};
			act_q   <= {regs_q[`TPG_IDX_ACT_HI], regs_q[`TPG_IDX_ACT_LO]};
			tot_q   <= {regs_q[`TPG_IDX_TOT_HI], regs_q[`TPG_IDX_TOT_LO]};
			pd_q    <= {regs_q[`TPG_IDX_PD_HI], regs_q[`TPG_IDX_PD_LO]};
			nbars_q <= 4'(4'h1 << color_bar_count);
			vbp_q   <= top_blank_lines;
		end
	end

	// ****************************************************************
	// line period unit divider and counter
	// ****************************************************************
	logic [15:0] div_q;    // clk cycles within one unit
	logic        unit_tick; // one pulse per period unit
	logic [15:0] per_q;    // units left in this line
	logic        line_go;  // a new line begins
	logic [15:0] pd_src;   // period of the line now starting

	assign unit_tick = (div_q == `TPG_UNIT_CLKS - 16'h0001);
	// first line of a frame takes the period captured with it
	assign pd_src    = (st_q == TPG_ST_FS) ? {regs_q[`TPG_IDX_PD_HI], regs_q[`TPG_IDX_PD_LO]} : pd_q;

	// divider for the link rate unit
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			div_q <= 16'h0000;
		else if (unit_tick)
			div_q <= 16'h0000;
		else
			div_q <= div_q + 16'h0001;
	end

	// units remaining in the current line
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			per_q <= 16'h0000;
		else if (line_go) // reaches zero after exactly one period
			per_q <= (pd_src == 16'h0000) ? 16'h0000 : pd_src - 16'h0001;
		else if (unit_tick && per_q != 16'h0000)
			per_q <= per_q - 16'h0001;
	end

	// ****************************************************************
	// line and byte sequencing
	// ****************************************************************
	logic [15:0] line_q;    // line within frame
	logic [15:0] byte_q;    // byte within active line
	logic [15:0] in_bar_q;  // byte within current bar
	logic [2:0]  bar_q;     // current bar
	logic        active;    // current line carries data
	logic        last_byte; // final byte of the line
	logic        last_line; // final line of the frame
	logic        bar_end;   // bar width reached
	logic [16:0] act_end;   // first line after active lines

	assign act_end   = 17'(vbp_q) + 17'(act_q);
	assign active    = (17'(line_q) >= 17'(vbp_q)) && (17'(line_q) < act_end);
	assign last_byte = (byte_q == len_q - 16'h0001);
	assign last_line = (line_q >= tot_q - 16'h0001) || (tot_q == 16'h0000);
	assign bar_end   = (in_bar_q == bar_w_q - 16'h0001);
	assign line_go   = (st_q == TPG_ST_FS && push) ||
	                   (st_q == TPG_ST_WAIT && per_q == 16'h0000 && !last_line);
	assign line_index = line_q;

	// state machine
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			st_q <= TPG_ST_FS;
		else
		begin
			case (st_q)
				TPG_ST_FS:
					if (push)
						st_q <= TPG_ST_LINE;
				TPG_ST_LINE: // data only on active lines
					st_q <= (active && len_q != 16'h0000) ? TPG_ST_DATA : TPG_ST_WAIT;
				TPG_ST_DATA:
					if (push && last_byte)
						st_q <= TPG_ST_WAIT;
				TPG_ST_WAIT: // hold until the period runs out
					if (per_q == 16'h0000)
						st_q <= last_line ? TPG_ST_FE : TPG_ST_LINE;
				TPG_ST_FE:
					if (push)
						st_q <= TPG_ST_FS;
				default:
					st_q <= TPG_ST_FS;
			endcase
		end
	end

	// line counter
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			line_q <= 16'h0000;
		else if (st_q == TPG_ST_FS)
			line_q <= 16'h0000;
		else if (line_go)
			line_q <= line_q + 16'h0001;
	end

	// byte and bar counters
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			byte_q   <= 16'h0000;
			in_bar_q <= 16'h0000;
			bar_q    <= 3'h0;
		end
		else if (st_q == TPG_ST_LINE)
		begin
			byte_q   <= 16'h0000;
			in_bar_q <= 16'h0000;
			bar_q    <= 3'h0;
		end
		else if (st_q == TPG_ST_DATA && push)
		begin
			byte_q <= byte_q + 16'h0001;
			if (bar_end && 4'(bar_q) < nbars_q - 4'h1)
			begin
				bar_q    <= bar_q + 3'h1;
				in_bar_q <= 16'h0000;
			end
			else
				in_bar_q <= in_bar_q + 16'h0001; // last bar runs to line end
		end
	end

	// ****************************************************************
	// beat generation and two-entry buffer
	// ****************************************************************
	tpg_beat_t gen_beat;  // beat offered this cycle
	logic      gen_valid; // a beat is offered

	// frame opens only while the path takes beats, so earlier setup applies to it
	assign gen_valid = (st_q == TPG_ST_FS && out_ready) || (st_q == TPG_ST_DATA) || (st_q == TPG_ST_FE);
	assign push      = gen_valid && buf_ready;

	// beat contents
	always_comb
	begin
		gen_beat            = '0;
		gen_beat.kind       = (st_q == TPG_ST_FS) ? TPG_BEAT_FS :
		                      (st_q == TPG_ST_FE) ? TPG_BEAT_FE : TPG_BEAT_DATA;
		gen_beat.line_first = (st_q == TPG_ST_DATA) && (byte_q == 16'h0000);
		gen_beat.line_last  = (st_q == TPG_ST_DATA) && last_byte;
		gen_beat.bar        = bar_q;
		gen_beat.line       = 16'(line_q - 16'(vbp_q));
	end

	tpg_beat_t mem_q [2]; // buffer entries
	logic      wp_q;      // write pointer
	logic      rp_q;      // read pointer
	logic [1:0] cnt_q;    // entries held
	logic      pop;       // beat taken by the path

	assign buf_ready = (cnt_q != 2'd2);
	assign out_valid = (cnt_q != 2'd0);
	assign pop       = out_valid && out_ready;
	assign out_beat  = mem_q[rp_q];

	// buffer storage and pointers
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			cnt_q    <= 2'd0;
		end
		else
		begin
			if (push)
			begin
				mem_q[wp_q] <= gen_beat;
				wp_q        <= ~wp_q;
			end
			if (pop)
				rp_q <= ~rp_q;
			cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
		end
	end

endmodule

/* sim/tpg_frame_timing_monitor.sv */
// port checker for the pattern timing core
`timescale 1ns/1ps
module tpg_frame_timing_monitor
	import tpg_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// packet path and status
	input wire logic        out_valid,
	input wire logic        out_ready,
	input wire tpg_beat_t   out_beat,
	input wire logic [15:0] line_index
);
	// ****
	// helper state
	// ****
	logic       pop;     // beat taken
	logic       dat;     // data beat taken
	logic       first_q; // next data beat opens a line
	logic [2:0] bar_q;   // bar of last data beat
	logic       open_q;  // inside a frame
	assign pop = out_valid && out_ready;
	assign dat = pop && out_beat.kind == TPG_BEAT_DATA;
	// follow taken beats
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			first_q <= 1'b1;
			bar_q   <= 3'h0;
			open_q  <= 1'b0;
		end
		else if (pop)
		begin
			if (dat)
			begin
				first_q <= out_beat.line_last;
				bar_q   <= out_beat.bar;
			end
			if (out_beat.kind == TPG_BEAT_FS)
				open_q <= 1'b1;
			if (out_beat.kind == TPG_BEAT_FE)
				open_q <= 1'b0;
		end
	end
	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	a_idle_after_reset: assert property ($rose(resetn) |-> !out_valid && line_index == 16'h0000)
		else $error("outputs busy after reset");
	a_beat_held: assert property (out_valid && !out_ready |=> out_valid && $stable(out_beat))
		else $error("beat lost during stall");
	a_reg_readback: assert property (reg_wr && reg_addr >= 8'h04 && reg_addr <= 8'h0D ##3
		reg_rd && reg_addr == $past(reg_addr, 3) |=> reg_rdata == $past(reg_wdata, 4)) else $error("readback wrong");
	a_rdata_kept: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	a_line_first: assert property (dat |-> out_beat.line_first == first_q)
		else $error("line start flag wrong");
	a_bar_step: assert property (dat |-> (out_beat.line_first ? out_beat.bar == 3'h0 :
		(out_beat.bar == bar_q || out_beat.bar == bar_q + 3'h1))) else $error("bar sequence wrong");
	a_frame_edges: assert property (pop && out_beat.kind != TPG_BEAT_DATA |->
		open_q == (out_beat.kind == TPG_BEAT_FE)) else $error("frame start and end out of order");
	a_data_inside: assert property (dat |-> open_q)
		else $error("data outside a frame");
	c_frame_end: cover property (pop && out_beat.kind == TPG_BEAT_FE);
	c_bar_four: cover property (dat && out_beat.bar == 3'h4);
	c_stall: cover property (out_valid && !out_ready [*2]);
endmodule

/* sim/tpg_pkt_sink.sv */
// packet path receiver model
`timescale 1ns/1ps
module tpg_pkt_sink
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// 0 hold off, 1 always take, 2 take half the time
	input  wire logic [1:0] mode,
	// handshake to the core
	output logic            out_ready
);
	logic [1:0] cnt_q; // stall pattern phase
	// moves only after the falling edge
	always @(negedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_q     <= 2'h0;
			out_ready <= 1'b0;
		end
		else
		begin
			cnt_q     <= cnt_q + 2'h1;
			out_ready <= (mode == 2'h1) || (mode == 2'h2 && cnt_q[1]);
		end
	end
endmodule

/* sim/tpg_frame_timing_test.sv */
// testbench for the pattern timing core
`timescale 1ns/1ps
bind tpg_frame_timing tpg_frame_timing_monitor u_mon
(
	.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat), .line_index(line_index)
);
module tpg_frame_timing_test;
	import tpg_pkg::*;
	localparam int PD  = 20; // line period
	localparam int VBP = 1;  // blank lines after start
	logic        clk, resetn, reg_wr, reg_rd, out_ready, out_valid;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
	logic [1:0]  color_bar_count, sink_mode;
	logic [7:0]  blank_lines; // blank lines ahead of data
	logic [15:0] line_index;
	tpg_beat_t   out_beat;
	int          failures, compares;
	logic [7:0]  rst_tbl [10] = '{8'h07, 8'h80, 8'h00, 8'hF0, 8'h01, 8'hE0, 8'h02, 8'h0D, 8'h0C, 8'h67};
	wire         pop = out_valid && out_ready;
	tpg_frame_timing DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .color_bar_count(color_bar_count), .top_blank_lines(blank_lines),
		.out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat), .line_index(line_index));
	tpg_pkt_sink u_sink (.clk(clk), .resetn(resetn), .mode(sink_mode), .out_ready(out_ready));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ****
	// shared tasks
	// ****
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one register access, q valid on return
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = w;
		reg_rd    = !w;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		@(negedge clk);
		q = reg_rdata;
	endtask
	// collect one frame, judge bars, lengths and timing
	task automatic run_frame(input int len, input int nb, input int judge, input int vb = VBP);
		int   k = 0, g = 0, n = 0, lines = 0, tfirst = 0;
		logic on = 1'b0, done = 1'b0;
		while (!done && g < 20000)
		begin
			@(posedge clk);
			g++;
			k++;
			if (pop && out_beat.kind == TPG_BEAT_FS)
			begin
				on = 1'b1;
				k  = 0;
				if (judge)
					check(line_index, 16'h0000);
			end
			if (on && pop && out_beat.kind == TPG_BEAT_DATA)
			begin
				n      = out_beat.line_first ? 0 : n;
				tfirst = (out_beat.line_first && lines == 0) ? k : tfirst;
				if (judge && out_beat.line_first)
					check(out_beat.line, lines);
				if (judge)
					check(out_beat.bar, (n / 2 < nb) ? n / 2 : nb - 1);
				n++;
				if (out_beat.line_last && judge)
					check(n, len);
				lines = out_beat.line_last ? lines + 1 : lines;
			end
			done = on && pop && out_beat.kind == TPG_BEAT_FE;
		end
		check(done, 1'b1);
		if (!done)
			tally_and_finish();
		else if (judge)
		begin
			check(lines, 2);
			check(k + 4 >= 4 * PD && k <= 4 * PD + 8, 1);
			check(tfirst + 4 >= vb * PD && tfirst <= vb * PD + 6, 1);
			if (sink_mode == 2'h1) // no stalls: exact line pacing
				check(k, 4 * PD + 1);
			if (sink_mode == 2'h1)
				check(tfirst, vb * PD + 2);
		end
	endtask
	// ****
	// scenarios
	// ****
	task automatic test_registers();
		for (int i = 0; i < 10; i++)
		begin
			acc(1'b0, 8'(4 + i), 8'h00, v);
			check(v, rst_tbl[i]);
			acc(1'b1, 8'(4 + i), 8'h5A ^ 8'(i), v);
			acc(1'b0, 8'(4 + i), 8'h00, v);
			check(v, 8'h5A ^ 8'(i));
		end
		acc(1'b0, 8'h0E, 8'h00, v);
		check(v, 8'h00);
		// line 9 bytes, bar 2, 2 active of 4 lines
		foreach (rst_tbl[i])
			acc(1'b1, 8'(4 + i), (i % 2 == 0) ? 8'h00 : 8'((i == 1) ? 9 : (i == 3) ? 2 : (i == 5) ? 2 : (i == 7) ? 4 : PD), v);
	endtask
	task automatic test_bars();
		for (int c = 0; c < 4; c++)
		begin
			@(negedge clk);
			color_bar_count = 2'(c);
			sink_mode       = c[0] ? 2'h2 : 2'h1;
			run_frame(9, 1 << c, 0);
			run_frame(9, 1 << c, 1);
		end
	endtask
	task automatic test_midframe_write();
		fork
			run_frame(9, 8, 1);
			begin
				repeat (40) @(negedge clk);
				acc(1'b1, 8'h05, 8'h05, v);
				blank_lines = 8'h02;
			end
		join
		run_frame(5, 8, 1, 2);
	endtask
	initial
	begin
		failures        = 0;
		compares        = 0;
		resetn          = 1'b0;
		reg_wr          = 1'b0;
		reg_rd          = 1'b0;
		reg_addr        = 8'h00;
		reg_wdata       = 8'h00;
		color_bar_count = 2'h0;
		blank_lines     = 8'(VBP);
		sink_mode       = 2'h0;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		test_registers();
		test_bars();
		test_midframe_write();
		tally_and_finish();
	end
endmodule
